// ---- irq_prio_ctrl.sv ----
// Priority selection registers for four source groups and the reset
// control and cause register, with routing of requests to two levels.
// Assumes rst_in is the power-on reset and all inputs are synchronous.
//
// Functional notes
// - Group three holds, bit 7 down, timer5 gate, a hole, serial2 rx, serial2 tx, charge-time unit, capcomp2, capcomp1 and real-time clock.
// - Group three bits 5 and 4 are read-only and read as 1.
// - Every implemented priority bit comes out of power-on reset as 1.
// - Unimplemented bits ignore writes and read as 0.
// - A priority bit of 1 means high level, 0 means low level.
// - Group four bits 7 down to 0 serve capture/compare units 10 down to 3.
// - The 32 Kbyte variant lacks capcomp 10 and 9 and timer7 gate, 12, 10 match and 7 overflow bits.
// - Group five holds, bit 7 down, timer7 gate, timers 12, 10, 8 match, timer7 overflow, timer6 match, timer5 overflow, timer4 match.
// - Group six has bit 4 for nonvolatile write and bits 2 to 0 for comparators 3 to 1; the rest is unimplemented.
// - Reset control bit 7 enables two priority levels, 0 is legacy single level, and it resets to 0.
// - A configuration mismatch reset clears bit 5; software sets it back to 1.
// - Reset control reports reset instruction, watchdog, power-down, power-on and brown-out causes; bits 3 and 2 are read-only.
// - Priority bits act only while the level enable is set.
// - External input 0 has no priority bit and is always high.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"

module irq_prio_ctrl
    import irq_prio_pkg::*;
#(
    parameter bit SMALL_FLASH = 1'b0
) (
    // Clock and reset
    input  wire logic            ref_clk_in,
    input  wire logic            rst_in,
    // Register port
    input  wire logic [`ADDR_W-1:0] addr_in,
    input  wire logic [7:0]      wdata_in,
    input  wire logic            wr_in,
    input  wire logic            rd_in,
    output logic      [7:0]      rdata_out,
    // Peripheral requests, group3 in 7:0 up to group6 in 31:24
    input  wire logic [`SRC_COUNT-1:0] source_req_in,
    input  wire logic            ext0_req_in,
    // Reset and wake-up cause events, one-cycle pulses
    input  wire logic            cfg_mismatch_event_in,
    input  wire logic            reset_instr_event_in,
    input  wire logic            watchdog_timeout_event_in,
    input  wire logic            power_down_event_in,
    input  wire logic            watchdog_clear_in,
    input  wire logic            brownout_event_in,
    // Dispatch toward the core
    output logic      [`SRC_COUNT-1:0] high_req_out,
    output logic      [`SRC_COUNT-1:0] low_req_out,
    output logic                 high_any_out,
    output logic                 low_any_out,
    // Control levels
    output logic                 priority_levels_enable_out,
    output logic                 soft_brownout_enable_out
);

    localparam reg8_t IMPL3 = `IMPL_GROUP3;
    localparam reg8_t IMPL4 = SMALL_FLASH ? `IMPL_GROUP4_SMALL
                                          : `IMPL_GROUP4;
    localparam reg8_t IMPL5 = SMALL_FLASH ? `IMPL_GROUP5_SMALL
                                          : `IMPL_GROUP5;
    localparam reg8_t IMPL6 = `IMPL_GROUP6;
    localparam reg8_t WR3   = IMPL3 & ~reg8_t'(`RO_GROUP3);

    reg8_t prio_group3;
    reg8_t prio_group4;
    reg8_t prio_group5;
    reg8_t prio_group6;
    reg8_t reset_control;
    reg8_t next_prio_group3;
    reg8_t next_prio_group4;
    reg8_t next_prio_group5;
    reg8_t next_prio_group6;
    reg8_t next_reset_control;
    reg8_t next_rdata;
    logic  next_levels_en;
    logic  next_soft_bor;
    src_vec_t prio_vec;
    src_vec_t impl_vec;

    // Priority registers: writes touch only writable implemented bits
    always_comb begin
        next_prio_group3 = prio_group3;
        next_prio_group4 = prio_group4;
        next_prio_group5 = prio_group5;
        next_prio_group6 = prio_group6;
        if (wr_in) begin
            unique case (addr_in)
                `OFS_PRIO_GROUP3:
                    next_prio_group3 = (prio_group3 & ~WR3)
                                       | (wdata_in & WR3);
                `OFS_PRIO_GROUP4:
                    next_prio_group4 = wdata_in & IMPL4;
                `OFS_PRIO_GROUP5:
                    next_prio_group5 = wdata_in & IMPL5;
                `OFS_PRIO_GROUP6:
                    next_prio_group6 = wdata_in & IMPL6;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prio_group3 <= IMPL3;
            prio_group4 <= IMPL4;
            prio_group5 <= IMPL5;
            prio_group6 <= IMPL6;
        end else begin
            prio_group3 <= next_prio_group3;
            prio_group4 <= next_prio_group4;
            prio_group5 <= next_prio_group5;
            prio_group6 <= next_prio_group6;
        end
    end

    // Reset control: software writes first, hardware events override
    always_comb begin
        next_reset_control = reset_control;
        if (wr_in && addr_in == `OFS_RESET_CONTROL) begin
            next_reset_control = (reset_control & ~reg8_t'(`RC_WRITE_MASK))
                                 | (wdata_in & `RC_WRITE_MASK);
        end
        if (cfg_mismatch_event_in) begin
            next_reset_control[`RC_CFG_MISMATCH_BIT] = 1'b0;
        end
        if (reset_instr_event_in) begin
            next_reset_control[`RC_RESET_INSTR_BIT] = 1'b0;
        end
        if (watchdog_clear_in) begin
            next_reset_control[`RC_WDT_TIMEOUT_BIT] = 1'b1;
            next_reset_control[`RC_POWER_DOWN_BIT]  = 1'b1;
        end
        if (watchdog_timeout_event_in) begin
            next_reset_control[`RC_WDT_TIMEOUT_BIT] = 1'b0;
        end
        if (power_down_event_in) begin
            next_reset_control[`RC_POWER_DOWN_BIT] = 1'b0;
        end
        if (brownout_event_in) begin
            next_reset_control[`RC_BROWNOUT_BIT] = 1'b0;
        end
        next_levels_en = next_reset_control[`RC_LEVELS_EN_BIT];
        next_soft_bor  = next_reset_control[`RC_SOFT_BOR_BIT];
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            reset_control              <= `RC_RESET_VALUE;
            priority_levels_enable_out <= 1'b0;
            soft_brownout_enable_out   <= 1'b1;
        end else begin
            reset_control              <= next_reset_control;
            priority_levels_enable_out <= next_levels_en;
            soft_brownout_enable_out   <= next_soft_bor;
        end
    end

    // Read data stands in the cycle after the read strobe only
    always_comb begin
        next_rdata = `REG_ZERO;
        if (rd_in) begin
            unique case (addr_in)
                `OFS_PRIO_GROUP3:   next_rdata = prio_group3 & IMPL3;
                `OFS_PRIO_GROUP4:   next_rdata = prio_group4 & IMPL4;
                `OFS_PRIO_GROUP5:   next_rdata = prio_group5 & IMPL5;
                `OFS_PRIO_GROUP6:   next_rdata = prio_group6 & IMPL6;
                `OFS_RESET_CONTROL: next_rdata = reset_control;
                default:            next_rdata = `REG_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_out <= `REG_ZERO;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    always_comb begin
        prio_vec = {prio_group6, prio_group5, prio_group4, prio_group3};
        impl_vec = {IMPL6, IMPL5, IMPL4, IMPL3};
    end

    prio_router #(
        .N            (`SRC_COUNT)
    ) u_router (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .req_in       (source_req_in),
        .prio_in      (prio_vec),
        .impl_in      (impl_vec),
        .levels_en_in (reset_control[`RC_LEVELS_EN_BIT]),
        .ext0_req_in  (ext0_req_in),
        .high_req_out (high_req_out),
        .low_req_out  (low_req_out),
        .high_any_out (high_any_out),
        .low_any_out  (low_any_out)
    );

endmodule

`default_nettype wire

// ---- irq_prio_defines.svh ----
// Constants of the interrupt priority and reset cause block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH

// Register word offsets on the plain register port
`define ADDR_W                 3
`define OFS_PRIO_GROUP3        3'h0
`define OFS_PRIO_GROUP4        3'h1
`define OFS_PRIO_GROUP5        3'h2
`define OFS_PRIO_GROUP6        3'h3
`define OFS_RESET_CONTROL      3'h4

// Implemented-bit masks, full variant
`define IMPL_GROUP3            8'hBF
`define IMPL_GROUP4            8'hFF
`define IMPL_GROUP5            8'hFF
`define IMPL_GROUP6            8'h17
// Implemented-bit masks, 32 Kbyte variant
`define IMPL_GROUP4_SMALL      8'h3F
`define IMPL_GROUP5_SMALL      8'h17
// Read-only bits of group three (serial2 rx and tx)
`define RO_GROUP3              8'h30

// Reset control register fields
`define RC_LEVELS_EN_BIT       7
`define RC_SOFT_BOR_BIT        6
`define RC_CFG_MISMATCH_BIT    5
`define RC_RESET_INSTR_BIT     4
`define RC_WDT_TIMEOUT_BIT     3
`define RC_POWER_DOWN_BIT      2
`define RC_POWER_ON_BIT        1
`define RC_BROWNOUT_BIT        0
`define RC_RESET_VALUE         8'h7C
`define RC_WRITE_MASK          8'hF3

// Source vector layout: group3 at 7:0 up to group6 at 31:24
`define SRC_COUNT              32
`define REG_ZERO               8'h00

`endif

// ---- irq_prio_pkg.sv ----
// Types shared by the interrupt priority and reset cause block.
// Assumes irq_prio_defines.svh is on the include path.
`include "irq_prio_defines.svh"

package irq_prio_pkg;
    typedef logic [7:0]              reg8_t;
    typedef logic [`SRC_COUNT-1:0]   src_vec_t;
    typedef logic [`ADDR_W-1:0]      reg_addr_t;
endpackage

// ---- prio_router.sv ----
// Steers each peripheral request to the high or low dispatch level.
// Assumes requests and priority bits are synchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"

module prio_router
    import irq_prio_pkg::*;
#(
    parameter int N = `SRC_COUNT
) (
    // Clock and reset
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    // Source requests and their priority selection
    input  wire logic [N-1:0] req_in,
    input  wire logic [N-1:0] prio_in,
    input  wire logic [N-1:0] impl_in,
    input  wire logic         levels_en_in,
    input  wire logic         ext0_req_in,
    // Dispatch toward the core
    output logic      [N-1:0] high_req_out,
    output logic      [N-1:0] low_req_out,
    output logic              high_any_out,
    output logic              low_any_out
);

    logic [N-1:0] next_high_req;
    logic [N-1:0] next_low_req;
    logic         next_high_any;
    logic         next_low_any;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_src
            // Single level when disabled: all on the high line
            always_comb begin
                next_high_req[i] = req_in[i] & impl_in[i]
                                   & (prio_in[i] | ~levels_en_in);
                next_low_req[i]  = req_in[i] & impl_in[i]
                                   & ~prio_in[i] & levels_en_in;
            end
        end
    endgenerate

    always_comb begin
        // External input 0 is always high priority
        next_high_any = (|next_high_req) | ext0_req_in;
        next_low_any  = |next_low_req;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            high_req_out <= '0;
            low_req_out  <= '0;
            high_any_out <= 1'b0;
            low_any_out  <= 1'b0;
        end else begin
            high_req_out <= next_high_req;
            low_req_out  <= next_low_req;
            high_any_out <= next_high_any;
            low_any_out  <= next_low_any;
        end
    end

endmodule

`default_nettype wire

// ---- irq_prio_monitor.sv ----
// Assertions on the ports of the priority and reset cause block.
// Assumes it is bound to irq_prio_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"

module irq_prio_monitor
    import irq_prio_pkg::*;
#(
    parameter bit SMALL_FLASH = 1'b0
) (
    // Clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    // Register port
    input  wire logic [`ADDR_W-1:0]    addr_in,
    input  wire logic [7:0]            wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    input  wire logic [7:0]            rdata_out,
    // Requests and events
    input  wire logic [`SRC_COUNT-1:0] source_req_in,
    input  wire logic                  ext0_req_in,
    input  wire logic                  cfg_mismatch_event_in,
    // Dispatch
    input  wire logic [`SRC_COUNT-1:0] high_req_out,
    input  wire logic [`SRC_COUNT-1:0] low_req_out,
    input  wire logic                  high_any_out,
    input  wire logic                  low_any_out,
    input  wire logic                  priority_levels_enable_out
);
    localparam logic [31:0] IMPL = SMALL_FLASH ? 32'h1717_3FBF
                                               : 32'h17FF_FFBF;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_unmapped_zero: assert property (
        rd_in && addr_in > 3'h4 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_group3_fixed: assert property (
        rd_in && addr_in == `OFS_PRIO_GROUP3 |=> rdata_out[6:4] == 3'b011)
        else $error("group three fixed bits wrong");
    chk_group6_holes: assert property (
        rd_in && addr_in == `OFS_PRIO_GROUP6 |=> (rdata_out & 8'hE8) == 8'h00)
        else $error("group six holes not zero");
    chk_enable_copy: assert property (
        wr_in && addr_in == `OFS_RESET_CONTROL
        |=> priority_levels_enable_out == $past(wdata_in[7]))
        else $error("level enable not taken from write");
    chk_legacy_single: assert property (
        !$past(priority_levels_enable_out)
        |-> low_req_out == '0 && !low_any_out)
        else $error("low level used in single level mode");
    chk_ext0_high: assert property (
        ext0_req_in |=> high_any_out)
        else $error("external input 0 not high");
    chk_levels_split: assert property (
        (high_req_out & low_req_out) == '0)
        else $error("source on both levels");
    chk_holes_quiet: assert property (
        ((high_req_out | low_req_out) & ~IMPL) == '0)
        else $error("unimplemented source routed");
    chk_src_routed: assert property (
        1'b1 |=> (high_req_out[0] | low_req_out[0]) == $past(source_req_in[0]))
        else $error("clock source not routed");
    chk_cfg_flag: assert property (
        cfg_mismatch_event_in ##1 (rd_in && addr_in == `OFS_RESET_CONTROL)
        |=> !rdata_out[5])
        else $error("mismatch flag not cleared");
    chk_low_any: assert property (
        low_any_out == (|low_req_out))
        else $error("low summary wrong");
endmodule

bind irq_prio_ctrl irq_prio_monitor #(.SMALL_FLASH(SMALL_FLASH)) u_mon (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .source_req_in(source_req_in),
    .ext0_req_in(ext0_req_in), .cfg_mismatch_event_in(cfg_mismatch_event_in),
    .high_req_out(high_req_out), .low_req_out(low_req_out),
    .high_any_out(high_any_out), .low_any_out(low_any_out),
    .priority_levels_enable_out(priority_levels_enable_out));
`default_nettype wire

// ---- irq_source_model.sv ----
// Peripheral request sources facing the priority block.
// Assumes the bench sets the wanted levels; lines move at clock edges.
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
    // Clock
    input  wire logic        ref_clk_in,
    // Wanted levels
    input  wire logic [31:0] pattern_in,
    input  wire logic        ext0_in,
    // Request lines
    output logic      [31:0] req_out,
    output logic             ext0_out
);
    logic [31:0] next_req;
    logic        next_ext0;

    always_comb begin
        next_req  = pattern_in;
        next_ext0 = ext0_in;
    end

    always_ff @(posedge ref_clk_in) begin
        req_out  <= next_req;
        ext0_out <= next_ext0;
    end
endmodule
`default_nettype wire

// ---- irq_prio_ctrl_tb.sv ----
// Self-checking bench for the priority and reset cause block.
// Assumes design, package and source model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"

module irq_prio_ctrl_tb;
    import irq_prio_pkg::*;
    typedef struct {string what; logic [31:0] exp;} note_t;
    localparam reg8_t WM[8] = '{8'h8F, 8'hFF, 8'hFF, 8'h17, 8'hF3,
                                8'h00, 8'h00, 8'h00};
    localparam reg8_t RV[8] = '{8'hBF, 8'hFF, 8'hFF, 8'h17, 8'h7C,
                                8'h00, 8'h00, 8'h00};
    // Read masks of the 32 Kbyte variant relative to the full one
    localparam reg8_t SM[8] = '{8'hFF, 8'h3F, 8'h17, 8'hFF, 8'hFF,
                                8'hFF, 8'hFF, 8'hFF};
    localparam src_vec_t SMALL_IMPL = 32'h1717_3FBF;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    reg_addr_t   addr_in = '0;
    reg8_t       wdata_in = '0;
    logic        wr_in = 1'b0, rd_in = 1'b0, ext0 = 1'b0;
    logic        rd_pend = 1'b0, rt_pend = 1'b0;
    logic [5:0]  ev = '0;
    src_vec_t    pattern = '0, src, high_req, low_req;
    reg8_t       rdata_out;
    logic        ext0_req, high_any, low_any;
    reg8_t       rdata_s;
    src_vec_t    high_s, low_s;
    logic        lvl_en, sbor_en;
    note_t       q[$];
    note_t       n;
    reg8_t       mdl[8];
    logic [31:0] seed = 32'h8BE1;
    int          n_mismatch = 0, compares = 0;

    always #50 ref_clk_in = ~ref_clk_in;

    irq_source_model SRC (.ref_clk_in(ref_clk_in), .pattern_in(pattern),
        .ext0_in(ext0), .req_out(src), .ext0_out(ext0_req));
    irq_prio_ctrl DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .source_req_in(src), .ext0_req_in(ext0_req),
        .cfg_mismatch_event_in(ev[0]), .reset_instr_event_in(ev[1]),
        .watchdog_timeout_event_in(ev[2]), .power_down_event_in(ev[3]),
        .watchdog_clear_in(ev[4]), .brownout_event_in(ev[5]),
        .high_req_out(high_req), .low_req_out(low_req),
        .high_any_out(high_any), .low_any_out(low_any),
        .priority_levels_enable_out(lvl_en),
        .soft_brownout_enable_out(sbor_en));
    irq_prio_ctrl #(.SMALL_FLASH(1'b1)) DUT_S (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_s),
        .source_req_in(src), .ext0_req_in(ext0_req),
        .cfg_mismatch_event_in(ev[0]), .reset_instr_event_in(ev[1]),
        .watchdog_timeout_event_in(ev[2]), .power_down_event_in(ev[3]),
        .watchdog_clear_in(ev[4]), .brownout_event_in(ev[5]),
        .high_req_out(high_s), .low_req_out(low_s), .high_any_out(),
        .low_any_out(), .priority_levels_enable_out(),
        .soft_brownout_enable_out());

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h8020_0003 : 32'h0);
    endfunction

    // One strobe cycle; strobes stay up until the next call or idle
    task automatic bus(logic w, reg_addr_t a, reg8_t d, logic [5:0] e);
        @(posedge ref_clk_in);
        if (w) mdl[a] = (mdl[a] & ~WM[a]) | (d & WM[a]);
        else begin
            q.push_back('{"rdata", {24'h0, mdl[a]}});
            q.push_back('{"rdata_small", {24'h0, mdl[a] & SM[a]}});
        end
        mdl[4] = mdl[4] & ~{2'b0, e[0], e[1], e[2], e[3], 1'b0, e[5]}
                 | {4'h0, e[4], e[4], 2'b0};
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        ev <= e;
    endtask

    task automatic idle();
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        ev <= 6'h00;
    endtask

    task automatic route(src_vec_t p, logic x);
        src_vec_t im, on;
        im = p & 32'h17FF_FFBF;
        on = mdl[4][7] ? im & {mdl[3], mdl[2], mdl[1], mdl[0]} : im;
        idle();
        pattern <= p;
        ext0 <= x;
        repeat (3) @(posedge ref_clk_in);
        q.push_back('{"high_req", on});
        q.push_back('{"low_req", im & ~on});
        q.push_back('{"any", {30'h0, (|on) | x, |(im & ~on)}});
        q.push_back('{"enables", {30'h0, mdl[4][7], mdl[4][6]}});
        q.push_back('{"high_small", on & SMALL_IMPL});
        q.push_back('{"low_small", im & SMALL_IMPL & ~on});
        rt_pend <= 1'b1;
        @(posedge ref_clk_in);
        rt_pend <= 1'b0;
    endtask

    task automatic check(logic [31:0] got);
        compares++;
        n = q.pop_front();
        if (got !== n.exp) begin
            $display("MISMATCH %s expected %h seen %h", n.what, n.exp, got);
            n_mismatch++;
        end
    endtask

    // Result watcher
    always @(posedge ref_clk_in) begin
        rd_pend <= rd_in;
        if (rd_pend) begin
            check({24'h0, rdata_out});
            check({24'h0, rdata_s});
        end
        if (rt_pend) begin
            check(high_req);
            check(low_req);
            check({30'h0, high_any, low_any});
            check({30'h0, lvl_en, sbor_en});
            check(high_s);
            check(low_s);
        end
    end

    task automatic give_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        mdl = RV;
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], 8'h00, 6'h00);
        for (int k = 0; k < 32; k++) begin
            seed = lfsr(seed);
            bus(1'b1, k[2:0], k < 8 ? 8'h00 : k < 16 ? 8'hFF : seed[7:0],
                6'h00);
            bus(1'b0, k[2:0], 8'h00, 6'h00);
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, `OFS_RESET_CONTROL, 8'h00, 6'h01 << i);
            bus(1'b0, `OFS_RESET_CONTROL, 8'h00, 6'h00);
            bus(1'b1, `OFS_RESET_CONTROL, 8'hFF, 6'h00);
        end
        bus(1'b1, `OFS_RESET_CONTROL, 8'hFF, 6'h01);
        bus(1'b0, `OFS_RESET_CONTROL, 8'h00, 6'h00);
        for (int k = 0; k < 24; k++) begin
            for (int j = 0; j < 4; j++) begin
                seed = lfsr(seed);
                bus(1'b1, j[2:0], seed[15:8], 6'h00);
            end
            bus(1'b1, `OFS_RESET_CONTROL, k < 12 ? 8'h73 : 8'hF3, 6'h00);
            seed = lfsr(seed);
            route(k == 0 ? '1 : seed, seed[0]);
        end
        idle();
        repeat (3) @(posedge ref_clk_in);
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
